// *** rtl/osm_pkg.sv ***
package osm_pkg;

  typedef enum logic [2:0] {
    OSM_INIT,
    OSM_NORMAL,
    OSM_STOP,
    OSM_SLEEP,
    OSM_RESTART,
    OSM_FAILSAFE
  } osm_mode_type;

  // system clock and timing
  localparam int SYS_CLK_MHZ = 200;
  localparam int RESET_DELAY_NS = 10000;
  localparam int RESET_DELAY_CYC = (RESET_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int IRQ_PULSE_NS = 500;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int WD_LONG_WINDOW_MS = 200;
  localparam int WD_LONG_WINDOW_CYC = WD_LONG_WINDOW_MS * SYS_CLK_MHZ * 1000;
  localparam int WD_WINDOW_MS = 20;
  localparam int WD_WINDOW_CYC = WD_WINDOW_MS * SYS_CLK_MHZ * 1000;

  // 16-bit frame layout
  localparam int FRAME_W = 16;
  localparam int FRM_WRITE_BIT = 15;
  localparam int FRM_WDTRIG_BIT = 3;
  localparam int FRM_MODE_LSB = 0;
  localparam int FRM_MODE_W = 3;

  // mode request field encodings
  localparam logic [2:0] MODE_REQ_NORMAL = 3'h0;
  localparam logic [2:0] MODE_REQ_STOP = 3'h1;
  localparam logic [2:0] MODE_REQ_SLEEP = 3'h2;
  localparam logic [2:0] MODE_REQ_SOFT_RESET = 3'h3;
  localparam logic [2:0] MODE_REQ_RESET_VAL = 3'h0;

  localparam int NUM_HV_WAKE = 3;

  typedef struct packed {
    logic wake_bus;
    logic [NUM_HV_WAKE-1:0] high_voltage_wake_inputs;
    logic main_regulator_undervoltage;
    logic overtemp;
    logic test_strap_n;
    logic cfg_pin;
  } osm_pins_type;

  // idle pin levels, used as synchroniser reset values
  localparam osm_pins_type PINS_IDLE = '{
    wake_bus: 1'b0,
    high_voltage_wake_inputs: '0,
    main_regulator_undervoltage: 1'b0,
    overtemp: 1'b0,
    test_strap_n: 1'b1,
    cfg_pin: 1'b0
  };

  typedef struct packed {
    logic main_regulator_output_en;
    logic mcu_reset_n;
    logic interrupt_n;
    logic dev_mode;
    osm_mode_type mode;
  } osm_out_type;

endpackage

// *** rtl/osm_spi_rx.sv ***
`timescale 1ns/1ps
module osm_spi_rx (
  input wire logic reset_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [2:0] status_mode,
  output logic spi_miso,
  output logic [osm_pkg::FRAME_W-1:0] rx_word,
  output logic rx_toggle
);

  typedef struct packed {
    logic [osm_pkg::FRAME_W-2:0] shift;
    logic [3:0] bit_cnt;
  } osm_frm_type;

  typedef struct packed {
    logic [2:0] stat_s1;
    logic [2:0] stat_s2;
    logic [osm_pkg::FRAME_W-1:0] word;
    logic toggle;
    logic miso;
  } osm_lnk_type;

  osm_frm_type f_q, f_d;
  osm_lnk_type l_q, l_d;
  logic frame_rst_n;
  logic [osm_pkg::FRAME_W-1:0] tx_word;

  // a deselected chip select clears the bit position, so a broken frame never counts
  assign frame_rst_n = reset_n & ~spi_cs_n;
  assign tx_word = {13'h0000, l_q.stat_s2};

  always_comb begin
    f_d = f_q;
    l_d = l_q;
    l_d.stat_s1 = status_mode;
    l_d.stat_s2 = l_q.stat_s1;
    f_d.shift = {f_q.shift[osm_pkg::FRAME_W-3:0], spi_mosi};
    f_d.bit_cnt = f_q.bit_cnt + 4'h1;
    if (f_q.bit_cnt == 4'hf) begin // [RL12]
      l_d.word = {f_q.shift, spi_mosi};
      l_d.toggle = ~l_q.toggle;
    end
    l_d.miso = tx_word[4'hf - f_d.bit_cnt];
  end

  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge spi_sck or negedge reset_n) begin
    if (!reset_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign spi_miso = l_q.miso;
  assign rx_word = l_q.word;
  assign rx_toggle = l_q.toggle;

endmodule

// *** rtl/osm_mode_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// RL1 - power-up or soft reset enters init
// RL2 - stop mode keeps main regulator on
// RL3 - sleep mode turns main regulator off
// RL4 - restart after sleep/fail-safe wake or failure
// RL5 - restart holds microcontroller reset low
// RL6 - failure gone plus reset delay gives normal
// RL7 - critical failure enters fail-safe, regulator off
// RL8 - fail-safe left by wake or overtemp clearing
// RL9 - development mode freezes the watchdog counter
// RL10 - strap low during init selects development
// RL11 - development mode allows all six modes
// RL12 - all control via 16-bit serial frames
// RL13 - external strap selects watchdog failure response
// RL14 - host writes mode field, restart clears it
// RL15 - any frame leaves init, wakes ignored
// RL16 - missed long window trigger forces restart; in normal the code picks restart or fail-safe by cfg_restart, stop runs no watchdog
// RL17 - wake in normal pulses interrupt only
// RL18 - sleep/fail-safe wake always passes restart
module osm_mode_ctrl #(
  parameter logic [31:0] WD_LONG_CYC = 32'(osm_pkg::WD_LONG_WINDOW_CYC),
  parameter logic [31:0] WD_WIN_CYC = 32'(osm_pkg::WD_WINDOW_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input osm_pkg::osm_pins_type pins,
  output osm_pkg::osm_out_type outs
);

  // bus wake plus the high-voltage wake inputs
  localparam int NUM_WAKE = osm_pkg::NUM_HV_WAKE + 1;
  localparam logic [31:0] RD_LAST = 32'(osm_pkg::RESET_DELAY_CYC - 1);
  localparam logic [31:0] IRQ_LEN = 32'(osm_pkg::IRQ_PULSE_CYC);

  typedef struct packed {
    // two-stage synchroniser for every pin
    osm_pkg::osm_pins_type pin_s1;
    osm_pkg::osm_pins_type pin_s2;
    logic [NUM_WAKE-1:0] wake_prev;

    // frame-done toggle crossing from the link clock
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;

    osm_pkg::osm_mode_type mode;
    logic [2:0] mode_req;

    // strap and configuration captured in init, and the overtemp fail-safe flag
    logic dev_mode;
    logic cfg_restart;
    logic cfg_locked;
    logic fs_by_overtemp;

    // watchdog and delay counters
    logic wd_long;
    logic [31:0] wd_cnt;
    logic [31:0] rd_cnt;
    logic [31:0] irq_cnt;

    osm_pkg::osm_out_type outs;
  } osm_ctl_type;

  localparam osm_ctl_type CTL_RESET = '{
    pin_s1: osm_pkg::PINS_IDLE,
    pin_s2: osm_pkg::PINS_IDLE,
    wake_prev: '0,
    tog_s1: 1'b0,
    tog_s2: 1'b0,
    tog_seen: 1'b0,
    mode: osm_pkg::OSM_INIT,
    mode_req: osm_pkg::MODE_REQ_RESET_VAL,
    dev_mode: 1'b0,
    cfg_restart: 1'b0,
    cfg_locked: 1'b0,
    fs_by_overtemp: 1'b0,
    wd_long: 1'b1,
    wd_cnt: 32'h00000000,
    rd_cnt: 32'h00000000,
    irq_cnt: 32'h00000000,
    outs: '{
      main_regulator_output_en: 1'b1,
      mcu_reset_n: 1'b0,
      interrupt_n: 1'b1,
      dev_mode: 1'b0,
      mode: osm_pkg::OSM_INIT
    }
  };

  osm_ctl_type st_q;
  osm_ctl_type st_d;

  logic [osm_pkg::FRAME_W-1:0] rx_word;
  logic rx_toggle;

  logic [NUM_WAKE-1:0] wake_now;
  logic [NUM_WAKE-1:0] wake_rise;
  logic wake_any;
  logic wake_edge;

  logic frame_evt;
  logic frame_write;
  logic frame_wdtrig;
  logic [2:0] frame_req;

  logic wd_counting;
  logic [31:0] wd_limit;
  logic wd_fail;
  logic uv_now;
  logic ot_now;

  // serial link logic lives in the link clock domain
  osm_spi_rx u_rx (
    .reset_n(reset_n),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .status_mode(st_q.outs.mode),
    .spi_miso(spi_miso),
    .rx_word(rx_word),
    .rx_toggle(rx_toggle)
  );

  assign wake_now = {st_q.pin_s2.wake_bus, st_q.pin_s2.high_voltage_wake_inputs};

  // prev resets to the idle level, so no false edge after reset
  for (genvar g = 0; g < NUM_WAKE; g++) begin : g_wake
    assign wake_rise[g] = wake_now[g] & ~st_q.wake_prev[g];
  end

  assign wake_any = |wake_now;
  assign wake_edge = |wake_rise;

  // rx_word is held until the next frame ends, long after the toggle settles
  assign frame_evt = st_q.tog_s2 ^ st_q.tog_seen;
  assign frame_write = rx_word[osm_pkg::FRM_WRITE_BIT];
  assign frame_wdtrig = rx_word[osm_pkg::FRM_WDTRIG_BIT];
  assign frame_req = rx_word[osm_pkg::FRM_MODE_LSB +: osm_pkg::FRM_MODE_W];

  assign uv_now = st_q.pin_s2.main_regulator_undervoltage;
  assign ot_now = st_q.pin_s2.overtemp;

  assign wd_counting = (st_q.mode == osm_pkg::OSM_INIT) || (st_q.mode == osm_pkg::OSM_NORMAL);
  assign wd_limit = st_q.wd_long ? (WD_LONG_CYC - 32'h00000001) : (WD_WIN_CYC - 32'h00000001);
  assign wd_fail = wd_counting && !st_q.dev_mode && (st_q.wd_cnt >= wd_limit); // [RL16]

  always_comb begin
    st_d = st_q;

    st_d.pin_s1 = pins;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.wake_prev = wake_now;

    st_d.tog_s1 = rx_toggle;
    st_d.tog_s2 = st_q.tog_s1;
    st_d.tog_seen = st_q.tog_s2;

    // watchdog: a trigger restarts the window, development mode freezes it
    if (frame_evt && frame_wdtrig) begin
      st_d.wd_cnt = 32'h00000000;
      st_d.wd_long = 1'b0;
    end else if (wd_counting && !st_q.dev_mode) begin
      st_d.wd_cnt = st_q.wd_cnt + 32'h00000001;
    end else if (!wd_counting) begin
      st_d.wd_cnt = 32'h00000000;
    end
    // [RL9] counter held while dev_mode is set

    if (st_q.irq_cnt != 32'h00000000) begin
      st_d.irq_cnt = st_q.irq_cnt - 32'h00000001;
    end

    unique case (st_q.mode)
      osm_pkg::OSM_INIT: begin
        st_d.dev_mode = ~st_q.pin_s2.test_strap_n; // [RL10]
        // config survives soft resets, only power-up takes it again
        if (!st_q.cfg_locked) begin
          st_d.cfg_restart = st_q.pin_s2.cfg_pin; // [RL13]
        end
        if (wd_fail) begin
          st_d.mode = osm_pkg::OSM_RESTART; // [RL16]
          st_d.cfg_locked = 1'b1;
        end else if (frame_evt) begin
          // any frame at all, wakes never looked at here
          st_d.mode = osm_pkg::OSM_NORMAL; // [RL15]
          st_d.cfg_locked = 1'b1;
        end
      end

      osm_pkg::OSM_NORMAL,
      osm_pkg::OSM_STOP: begin
        if (wake_edge) begin
          st_d.irq_cnt = IRQ_LEN; // [RL17]
        end
        if (ot_now) begin
          st_d.mode = osm_pkg::OSM_FAILSAFE; // [RL7]
          st_d.fs_by_overtemp = 1'b1;
        end else if (wd_fail) begin
          st_d.mode = st_q.cfg_restart ? osm_pkg::OSM_RESTART : osm_pkg::OSM_FAILSAFE; // [RL4] [RL7] [RL13]
          st_d.fs_by_overtemp = 1'b0;
        end else if (uv_now) begin
          st_d.mode = osm_pkg::OSM_RESTART; // [RL4]
        end else if (frame_evt && frame_write) begin
          st_d.mode_req = frame_req; // [RL14]
          case (frame_req)
            osm_pkg::MODE_REQ_NORMAL: begin
              st_d.mode = osm_pkg::OSM_NORMAL;
            end
            osm_pkg::MODE_REQ_STOP: begin
              st_d.mode = osm_pkg::OSM_STOP; // [RL2]
            end
            osm_pkg::MODE_REQ_SLEEP: begin
              st_d.mode = osm_pkg::OSM_SLEEP; // [RL3]
            end
            osm_pkg::MODE_REQ_SOFT_RESET: begin
              st_d.mode = osm_pkg::OSM_INIT; // [RL1]
              st_d.wd_long = 1'b1;
              st_d.wd_cnt = 32'h00000000;
            end
            default: begin
              // unused codes leave the mode alone
              st_d.mode = st_q.mode;
            end
          endcase
        end
      end

      osm_pkg::OSM_SLEEP: begin
        // level, not edge: a wake already present must not be lost
        if (wake_any) begin
          st_d.mode = osm_pkg::OSM_RESTART; // [RL4] [RL18]
        end
      end

      osm_pkg::OSM_FAILSAFE: begin
        if (wake_any || (st_q.fs_by_overtemp && !ot_now)) begin // [RL8]
          st_d.mode = osm_pkg::OSM_RESTART; // [RL4] [RL18]
          st_d.fs_by_overtemp = 1'b0;
        end
      end

      osm_pkg::OSM_RESTART: begin
        st_d.mode_req = osm_pkg::MODE_REQ_RESET_VAL; // [RL14]
        st_d.wd_long = 1'b1;
        // the delay only runs while no failure is present
        if (uv_now || ot_now) begin
          st_d.rd_cnt = 32'h00000000;
        end else if (st_q.rd_cnt >= RD_LAST) begin
          st_d.mode = osm_pkg::OSM_NORMAL; // [RL6]
        end else begin
          st_d.rd_cnt = st_q.rd_cnt + 32'h00000001;
        end
      end
    endcase

    if ((st_d.mode == osm_pkg::OSM_RESTART) && (st_q.mode != osm_pkg::OSM_RESTART)) begin
      st_d.rd_cnt = 32'h00000000;
    end

    // [RL11] development mode gates nothing but the watchdog
    st_d.outs.mode = st_d.mode;
    st_d.outs.main_regulator_output_en = (st_d.mode != osm_pkg::OSM_SLEEP) &&
      (st_d.mode != osm_pkg::OSM_FAILSAFE); // [RL2] [RL3] [RL7]
    st_d.outs.mcu_reset_n = (st_d.mode != osm_pkg::OSM_RESTART); // [RL5]
    st_d.outs.interrupt_n = (st_d.irq_cnt == 32'h00000000); // [RL17]
    st_d.outs.dev_mode = st_d.dev_mode; // [RL9]
  end

  // [RL12] all commands arrive through u_rx frames

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= CTL_RESET; // [RL1]
    end else begin
      st_q <= st_d;
    end
  end

  assign outs = st_q.outs;

endmodule

// *** verification/osm_host_model.sv ***
`timescale 1ns/1ps
module osm_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial {spi_sck, spi_cs_n, spi_mosi} = 3'h3;
  // msb first, clock still between frames
  task automatic send(input logic [15:0] w);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #6 spi_sck = 1'b1;
      #6 spi_sck = 1'b0;
    end
    #6 {spi_cs_n, spi_mosi} = {1'b1, ~w[0]};
    // idle gap so back-to-back frames see a deselect
    #6;
  endtask
endmodule

// *** verification/osm_monitor.sv ***
`timescale 1ns/1ps
module osm_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input osm_pkg::osm_pins_type pins,
  input osm_pkg::osm_out_type outs
);
  logic [2:0] m;
  logic en;
  assign m = outs.mode;
  assign en = outs.main_regulator_output_en;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  stop_on_a: assert property (m == 3'h2 |-> en) else $error("stop");
  sleep_off_a: assert property (m == 3'h3 |-> !en) else $error("sleep");
  failsafe_off_a: assert property (m == 3'h5 |-> !en) else $error("fs");
  restart_hold_a: assert property (m == 3'h4 |-> !outs.mcu_reset_n) else $error("rst");
  via_restart_a: assert property (m == 3'h1 |-> !($past(m) inside {3'h3, 3'h5})) else $error("direct");
  sleep_wake_a: assert property (m == 3'h3 && pins.wake_bus |-> ##[1:4] m == 3'h4) else $error("wake");
  restart_exit_a: assert property ($past(m) == 3'h4 && m != 3'h4 |-> m == 3'h1) else $error("exit");
  normal_wake_a: assert property (m == 3'h1 && $rose(pins.wake_bus) |=> m == 3'h1) else $error("nwake");
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sck, cs_n, mosi;
  // strap low: development mode keeps the watchdog quiet
  osm_pkg::osm_pins_type pins = '0;
  osm_pkg::osm_out_type outs;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [5:0] rows [3] = '{6'h0a, 6'h01, 6'h13};
  initial forever #2.5 clk_sys = ~clk_sys;
  osm_host_model u_host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi));
  osm_mode_ctrl #(.WD_LONG_CYC(32'h00000100)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(), .pins(pins), .outs(outs));
  task automatic chk_bit(input logic v, input logic e);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("ERROR %0t bit %0b", $time, v);
    end
  endtask
  task automatic chk(input logic [2:0] m, input int n);
    while (outs.mode !== m && n-- > 0) @(negedge clk_sys);
    samples_checked++;
    if (outs.mode !== m) begin
      fails++;
      $display("ERROR %0t mode %0d", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(3'h0, 2);
    repeat (4) @(negedge clk_sys);
    chk_bit(outs.dev_mode, 1'b1);
    u_host.send(16'h0000);
    chk(3'h1, 99);
    foreach (rows[i]) begin
      u_host.send({13'h1001, rows[i][5:3]});
      chk(rows[i][2:0], 99);
      $display("row %0d done", i);
    end
    @(negedge clk_sys);
    pins.wake_bus = 1'b1;
    chk(3'h4, 9);
    pins.wake_bus = 1'b0;
    chk(3'h1, osm_pkg::RESET_DELAY_CYC + 99);
    pins.wake_bus = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk_bit(outs.interrupt_n, 1'b0);
    chk(3'h1, 0);
    pins.wake_bus = 1'b0;
    pins.overtemp = 1'b1;
    chk(3'h5, 9);
    chk_bit(outs.main_regulator_output_en, 1'b0);
    pins.overtemp = 1'b0;
    chk(3'h4, 9);
    chk(3'h1, osm_pkg::RESET_DELAY_CYC + 99);
    $display("wake and fail-safe done");
    pins.main_regulator_undervoltage = 1'b1;
    chk(3'h4, 9);
    repeat (osm_pkg::RESET_DELAY_CYC + 20) @(negedge clk_sys);
    chk(3'h4, 0);
    pins.main_regulator_undervoltage = 1'b0;
    chk(3'h1, osm_pkg::RESET_DELAY_CYC + 99);
    u_host.send(16'h8003);
    chk(3'h0, 99);
    u_host.send(16'h8008);
    chk(3'h1, 99);
    $display("undervoltage and soft reset done");
    reset_n = 1'b0;
    pins.test_strap_n = 1'b1;
    pins.cfg_pin = 1'b1;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(3'h0, 2);
    repeat (4) @(negedge clk_sys);
    chk_bit(outs.dev_mode, 1'b0);
    chk(3'h4, 300);
    chk(3'h1, osm_pkg::RESET_DELAY_CYC + 99);
    $display("watchdog start-up done");
    give_verdict;
  end
endmodule
bind osm_mode_ctrl osm_monitor u_mon (.clk_sys(clk_sys), .reset_n(reset_n), .pins(pins), .outs(outs));
